// file: atu_pkg.sv
// package for the angle trigger unit: register map, field layout, modes
// assumes a 32-bit avalon-mm slave with word addressing in bytes
package atu_pkg;
	// register byte offsets
	localparam logic [7:0] ATU_REG_CTRL = 8'h00;
	localparam logic [7:0] ATU_REG_SPAN = 8'h04;
	localparam logic [7:0] ATU_REG_TOOTH = 8'h08;
	localparam logic [7:0] ATU_REG_DELAY = 8'h0c;
	localparam logic [7:0] ATU_REG_STATUS = 8'h10;
	localparam logic [7:0] ATU_REG_ANGLE = 8'h14;
	localparam logic [7:0] ATU_REG_BOARD = 8'h18;
	// control fields
	localparam int ATU_CTRL_MODE_LSB = 0;
	localparam int ATU_CTRL_GATE_BIT = 2;
	// field widths and limits
	localparam int ATU_CNT_W = 15;
	localparam int ATU_TOOTH_W = 11;
	localparam logic [14:0] ATU_SPAN_MIN = 15'h0002;
	localparam logic [14:0] ATU_SPAN_MAX = 15'h7fff;
	localparam logic [14:0] ATU_SPAN_RST = 15'h0002;
	localparam logic [10:0] ATU_TOOTH_MIN = 11'h001;
	localparam logic [10:0] ATU_TOOTH_MAX = 11'h5a0;
	localparam logic [10:0] ATU_TOOTH_RST = 11'h001;
	localparam logic [15:0] ATU_DELAY_RST = 16'h0000;
	localparam int ATU_ID_W = 2;
	localparam logic [31:0] ATU_UNMAPPED = 32'h0000_0000;
	// trigger modes, encoded as written to the control field
	typedef enum logic [1:0] {
		ATU_MODE_OFF = 2'h0,
		ATU_MODE_RISE = 2'h1,
		ATU_MODE_STATE = 2'h2,
		ATU_MODE_ANGLE = 2'h3
	} atu_mode_e;
endpackage : atu_pkg

// file: atu_angle_trigger_unit.sv
// angle trigger unit: hardware trigger decision for a digital i/o board
// assumes trigger inputs already synchronous to clk; one avalon-mm slave
`timescale 1ns/100ps

// Functional notes
// - off mode ignores both trigger inputs
// - rising edge mode starts on qualified rise
// - signal state mode: rise opens, fall closes
// - request delay not shorter than hold: no start
// - angle mode treats both inputs as pulses
// - angle mode: input 1 rise clears counter
// - angle mode: input 2 fall increments counter
// - position is counted input 2 periods
// - gate off: every selected edge triggers
// - gate on: rise and state modes trigger only while input 2 high
// - rise and state modes may use gating
// - angle forces gate on; off locks gate
// - zero span two to 32767 teeth
// - tooth width half degree steps to 720
// - board id assigned at power-on, max four
module atu_angle_trigger_unit
	import atu_pkg::*;
#(
	parameter int CNT_W = ATU_CNT_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic trig_in1,
	input wire logic trig_in2,
	input wire logic [ATU_ID_W-1:0] slot_id,
	output logic start_pulse,
	output logic active_level,
	output logic zero_pulse,
	output logic [CNT_W-1:0] angle_count
);

	////////////////////////////////////////////////////////////////////////
	// register bus

	atu_mode_e mode_q;
	logic gate_q;
	logic [14:0] span_q;
	logic [10:0] tooth_q;
	logic [15:0] delay_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic wr_ctrl;
	logic [ATU_ID_W-1:0] board_id_q;
	logic id_taken_q;
	logic [31:0] wdata;
	logic [31:0] status_w;

	// one wait cycle per access, then acked
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign avs_readdata = rdata_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	// byte-enable mask on the write data, disabled bytes forced to zero
	always_comb begin
		wdata = 32'h0000_0000;
		for (int b = 0; b < 4; b++) begin
			wdata[b*8 +: 8] = avs_byteenable[b] ? avs_writedata[b*8 +: 8] : 8'h00;
		end
	end

	// writes land on the edge where waitrequest is seen low, as the master expects
	assign wr_ctrl = avs_write & ack_q & (avs_address == ATU_REG_CTRL)
		& avs_byteenable[0];

	// mode and gate; angle forces gate, off freezes it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q <= ATU_MODE_OFF;
			gate_q <= 1'b0;
		end else if (wr_ctrl) begin
			mode_q <= atu_mode_e'(wdata[ATU_CTRL_MODE_LSB +: 2]);
			if (atu_mode_e'(wdata[ATU_CTRL_MODE_LSB +: 2]) == ATU_MODE_ANGLE) begin
				gate_q <= 1'b1;
			end else if (mode_q != ATU_MODE_OFF) begin
				gate_q <= wdata[ATU_CTRL_GATE_BIT];
			end
		end
	end

	// span and tooth width, clamped to their legal ranges; written only in angle mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			span_q <= ATU_SPAN_RST;
			tooth_q <= ATU_TOOTH_RST;
		end else if (avs_write & ack_q & (mode_q == ATU_MODE_ANGLE)) begin
			if (avs_address == ATU_REG_SPAN && avs_byteenable[1:0] == 2'h3) begin
				if (wdata[14:0] < ATU_SPAN_MIN) begin
					span_q <= ATU_SPAN_MIN;
				end else begin
					span_q <= wdata[14:0];
				end
			end
			if (avs_address == ATU_REG_TOOTH && avs_byteenable[1:0] == 2'h3) begin
				if (wdata[10:0] < ATU_TOOTH_MIN) begin
					tooth_q <= ATU_TOOTH_MIN;
				end else if (wdata[10:0] > ATU_TOOTH_MAX) begin
					tooth_q <= ATU_TOOTH_MAX;
				end else begin
					tooth_q <= wdata[10:0];
				end
			end
		end
	end

	// request delay in clock cycles for signal-state mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			delay_q <= ATU_DELAY_RST;
		end else if (avs_write & ack_q & (avs_address == ATU_REG_DELAY)) begin
			if (avs_byteenable[0]) delay_q[7:0] <= wdata[7:0];
			if (avs_byteenable[1]) delay_q[15:8] <= wdata[15:8];
		end
	end

	// id strap caught once after reset release, not under the reset itself
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			board_id_q <= '0;
			id_taken_q <= 1'b0;
		end else if (!id_taken_q) begin
			board_id_q <= slot_id;
			id_taken_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trigger evaluation

	logic in1_q;
	logic in2_q;
	logic rise1;
	logic fall1;
	logic fall2;
	logic gate_ok;
	logic period_q;
	logic [15:0] hold_q;
	logic started_q;
	logic start_d;
	logic [CNT_W-1:0] cnt_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in1_q <= 1'b0;
			in2_q <= 1'b0;
		end else begin
			in1_q <= trig_in1;
			in2_q <= trig_in2;
		end
	end

	// edge detection; off mode masks everything
	assign rise1 = (mode_q != ATU_MODE_OFF) & trig_in1 & ~in1_q;
	assign fall1 = (mode_q != ATU_MODE_OFF) & ~trig_in1 & in1_q;
	assign fall2 = (mode_q == ATU_MODE_ANGLE) & ~trig_in2 & in2_q;
	// gate level on input 2 qualifies input 1 rising edges
	assign gate_ok = ~gate_q | trig_in2;

	// signal-state period and hold time counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			period_q <= 1'b0;
			hold_q <= 16'h0000;
			started_q <= 1'b0;
		end else if (mode_q != ATU_MODE_STATE) begin
			period_q <= 1'b0;
			hold_q <= 16'h0000;
			started_q <= 1'b0;
		end else if (rise1 & gate_ok) begin
			period_q <= 1'b1;
			hold_q <= 16'h0000;
			started_q <= 1'b0;
		end else if (fall1) begin
			period_q <= 1'b0;
		end else if (period_q) begin
			if (hold_q != 16'hffff) hold_q <= hold_q + 16'h0001;
			if (start_d) started_q <= 1'b1;
		end
	end

	// start: rise mode on qualified edge; state mode once delay elapsed in period
	always_comb begin
		start_d = 1'b0;
		unique case (mode_q)
			ATU_MODE_OFF: start_d = 1'b0;
			ATU_MODE_RISE: start_d = rise1 & gate_ok;
			// delay reaching the hold means no start at all
			ATU_MODE_STATE: start_d = period_q & ~fall1 & ~started_q
				& (hold_q == delay_q);
			ATU_MODE_ANGLE: start_d = rise1;
		endcase
	end

	// angle segment counter, saturating at all ones of CNT_W bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (mode_q != ATU_MODE_ANGLE) begin
			cnt_q <= '0;
		end else if (rise1) begin
			cnt_q <= '0;
		end else if (fall2 && cnt_q != {CNT_W{1'b1}}) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// outputs from flip-flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_pulse <= 1'b0;
			zero_pulse <= 1'b0;
			active_level <= 1'b0;
			angle_count <= '0;
		end else begin
			start_pulse <= start_d;
			zero_pulse <= (mode_q == ATU_MODE_ANGLE) & rise1;
			active_level <= period_q & ~fall1 & (started_q | start_d);
			angle_count <= cnt_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux

	assign status_w = {28'h0, started_q, period_q, in2_q, in1_q};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read & ~ack_q) begin
			unique case (avs_address)
				ATU_REG_CTRL: rdata_q <= {29'h0, gate_q, mode_q};
				ATU_REG_SPAN: rdata_q <= {17'h0, span_q};
				ATU_REG_TOOTH: rdata_q <= {21'h0, tooth_q};
				ATU_REG_DELAY: rdata_q <= {16'h0, delay_q};
				ATU_REG_STATUS: rdata_q <= status_w;
				ATU_REG_ANGLE: rdata_q <= 32'(cnt_q);
				ATU_REG_BOARD: rdata_q <= {30'h0, board_id_q};
				default: rdata_q <= ATU_UNMAPPED;
			endcase
		end
	end

endmodule : atu_angle_trigger_unit

// file: atu_asserts.sv
// port checker for the angle trigger unit
// assumes the bench's bus master; bound into the unit below
`timescale 1ns/100ps
module atu_asserts
	import atu_pkg::*;
#(parameter int CNT_W = ATU_CNT_W) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic trig_in1,
	input wire logic trig_in2,
	input wire logic start_pulse,
	input wire logic active_level,
	input wire logic zero_pulse,
	input wire logic [CNT_W-1:0] angle_count
);
	atu_mode_e md_q;
	logic gt_q;
	// mirror of mode and gate; a gate write is lost while still off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			md_q <= ATU_MODE_OFF;
			gt_q <= 1'b0;
		end else if (avs_write && !avs_waitrequest && avs_address == ATU_REG_CTRL) begin
			md_q <= atu_mode_e'(avs_writedata[1:0]);
			gt_q <= (&avs_writedata[1:0]) | (md_q == ATU_MODE_OFF ? gt_q : avs_writedata[2]);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	//////////////////////////////////////////
	property p_wt; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_wt: assert property (p_wt) else $error("late answer");
	property p_sp; start_pulse |=> !start_pulse; endproperty
	a_sp: assert property (p_sp) else $error("long start");
	property p_of; md_q == ATU_MODE_OFF && $past(md_q) == ATU_MODE_OFF |-> !start_pulse; endproperty
	a_of: assert property (p_of) else $error("start when off");
	property p_rs; md_q == ATU_MODE_RISE && $rose(trig_in1) && (!gt_q || trig_in2) |=> start_pulse;
	endproperty
	a_rs: assert property (p_rs) else $error("no start");
	property p_gs; md_q == ATU_MODE_RISE && gt_q && !trig_in2 && $rose(trig_in1) |=> !start_pulse;
	endproperty
	a_gs: assert property (p_gs) else $error("gated start");
	property p_cl; md_q == ATU_MODE_STATE && $fell(trig_in1) |=> !active_level; endproperty
	a_cl: assert property (p_cl) else $error("period open");
	property p_zr; md_q == ATU_MODE_ANGLE && $rose(trig_in1) && trig_in2
		|=> zero_pulse ##1 angle_count == 0; endproperty
	a_zr: assert property (p_zr) else $error("no clear");
	property p_th; md_q == ATU_MODE_ANGLE && $fell(trig_in2) && !$rose(trig_in1)
		&& !(&angle_count) |=> ##1 angle_count == $past(angle_count) + 1; endproperty
	a_th: assert property (p_th) else $error("no step");
	c_st: cover property (start_pulse);
	c_al: cover property (active_level);
	c_zr: cover property (zero_pulse);
endmodule : atu_asserts
bind atu_angle_trigger_unit atu_asserts #(.CNT_W(CNT_W)) i_atu_asserts (.*);

// file: atu_crank_src.sv
// trigger source: manual levels, or a crank wheel when run is high
// assumes the bench drives man1, man2 and run at the rising edge
`timescale 1ns/100ps
module atu_crank_src #(parameter int TEETH = 5) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic man1,
	input wire logic man2,
	output logic trig1,
	output logic trig2
);
	logic [7:0] ph_q;
	// wheel phase, four cycles per tooth, no gaps in the tooth train
	always_ff @(posedge clk or posedge rst) begin
		if (rst || !run || ph_q == 4 * TEETH - 1) ph_q <= 8'h00;
		else ph_q <= ph_q + 8'h01;
	end
	assign trig2 = run ? (ph_q[1:0] < 2'h2) : man2;
	// zero mark drops between a tooth fall and the next rise
	assign trig1 = run ? (ph_q < 8'h03) : man1;
endmodule : atu_crank_src

// file: atu_angle_trigger_unit_tb_top.sv
// bench for the angle trigger unit: bus tasks and scripted trigger cases
// assumes the crank source model and the bound checker
`timescale 1ns/100ps
module atu_angle_trigger_unit_tb_top
	import atu_pkg::*;
;
	localparam int TEETH = 5;
	logic clk = 0, rst = 1, rd = 0, wr = 0, m1 = 0, m2 = 0, run = 0;
	logic [7:0] ad = 8'h00;
	logic [31:0] wd = 32'h0, rdat, q;
	logic [1:0] sid = 2'h2;
	logic t1, t2, sp, al, zp, wt;
	logic [ATU_CNT_W-1:0] cnt;
	int bad_count = 0, total_checks = 0, cyc = 0, n_st = 0, n_al = 0;
	always #4 clk = ~clk;
	atu_angle_trigger_unit i_atu_angle_trigger_unit (.clk(clk), .rst(rst), .avs_address(ad),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
		.avs_readdata(rdat), .avs_waitrequest(wt), .trig_in1(t1), .trig_in2(t2),
		.slot_id(sid), .start_pulse(sp), .active_level(al), .zero_pulse(zp), .angle_count(cnt));
	atu_crank_src #(.TEETH(TEETH)) i_atu_crank_src (.clk(clk), .rst(rst), .run(run),
		.man1(m1), .man2(m2), .trig1(t1), .trig2(t2));
	// start counter and hang guard
	always @(posedge clk) begin
		n_st <= n_st + sp;
		n_al <= n_al + al;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			final_report();
		end
	end
	//////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// one request held until waitrequest is seen low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		ad <= a;
		wd <= d;
		do @(posedge clk); while (wt !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rdc
	// input 1 high for n cycles, then count the starts it caused
	task pls(input int n, input int e, input int ea);
		int s0;
		int a0;
		@(posedge clk);
		s0 = n_st;
		a0 = n_al;
		m1 <= 1'b1;
		repeat (n) @(posedge clk);
		m1 <= 1'b0;
		repeat (6) @(posedge clk);
		chk(n_st - s0, e);
		chk(n_al - a0, ea);
	endtask : pls
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdc(ATU_REG_SPAN, 32'h2);
		rdc(ATU_REG_TOOTH, 32'h1);
		rdc(ATU_REG_BOARD, 32'h2);
		rdc(8'h1c, 32'h0);
		bus(1'b1, ATU_REG_CTRL, 32'h4);
		rdc(ATU_REG_CTRL, 32'h0);
		pls(3, 0, 0);
		bus(1'b1, ATU_REG_CTRL, 32'h1);
		pls(3, 1, 0);
		bus(1'b1, ATU_REG_SPAN, 32'h9);
		rdc(ATU_REG_SPAN, 32'h2);
		bus(1'b1, ATU_REG_CTRL, 32'h5);
		rdc(ATU_REG_CTRL, 32'h5);
		pls(3, 0, 0);
		m2 <= 1'b1;
		pls(3, 1, 0);
		bus(1'b1, ATU_REG_DELAY, 32'h3);
		bus(1'b1, ATU_REG_CTRL, 32'h6);
		pls(10, 1, 6);
		pls(2, 0, 0);
		bus(1'b1, ATU_REG_CTRL, 32'h3);
		rdc(ATU_REG_CTRL, 32'h7);
		bus(1'b1, ATU_REG_SPAN, 32'h7fff);
		rdc(ATU_REG_SPAN, 32'h7fff);
		bus(1'b1, ATU_REG_TOOTH, 32'h5a0);
		rdc(ATU_REG_TOOTH, 32'h5a0);
		run <= 1'b1;
		// first zero mark starts the wheel, the second ends a full turn
		repeat (2) do @(negedge clk); while (zp !== 1'b1);
		chk(cnt, TEETH);
		final_report();
	end
endmodule : atu_angle_trigger_unit_tb_top
